// File: verilog/lcsm_top.sv
`default_nettype none

module lcsm_top
   import lcsm_pkg::*;
#(
   parameter longint unsigned INACT_COUNT = INACT_CYCLES,
   parameter int unsigned     SCHED_W     = 8,
   parameter int unsigned     FAULT_W     = 16
) (
   // Clock and reset
   input  wire logic                 CLK_I,
   input  wire logic                 RST_I,
   // Host control, same clock domain
   input  wire logic                 START_I,
   input  wire logic                 STOP_I,
   input  wire logic                 SLEEP_REQ_I,
   input  wire logic                 WAKE_REQ_I,
   input  wire logic                 MASTER_I,
   input  wire logic [SCHED_W-1:0]   SCHED_IDX_I,
   // Frame engine events, same clock domain
   input  wire logic                 BREAK_SEEN_I,
   input  wire logic                 HEADER_SEEN_I,
   input  wire lcsm_err_t            ERR_I,
   input  wire logic                 FAULT_I,
   input  wire logic [FAULT_W-1:0]   FAULT_CODE_I,
   input  wire logic                 FAULT_CLR_I,
   // Transceiver pin, asynchronous
   input  wire logic                 BUS_PWR_I,
   // Status snapshot
   output logic [1:0]                COMM_STATE_O,
   output logic                      COMM_EN_O,
   output logic                      SLEEP_O,
   output logic                      XCVR_READY_O,
   output lcsm_err_snap_t            LAST_ERR_O,
   output logic                      FAULT_O,
   output logic [FAULT_W-1:0]        FAULT_CODE_O,
   output logic [SCHED_W-1:0]        SCHED_IDX_O
);

   // ==========================================================
   // Parameter checks
   // The idle counter is 32 bits wide and the fault constants are 16 bits, so larger values cannot be served.
   if (INACT_COUNT < 2 || INACT_COUNT > 64'h0000_0000_FFFF_FFFF) begin : g_bad_count
      $error("INACT_COUNT out of range");
   end
   if (SCHED_W < 1 || FAULT_W < 1 || FAULT_W > 16) begin : g_bad_width
      $error("width parameter out of range");
   end

   localparam logic [31:0] CNT_LAST = 32'(INACT_COUNT - 1);

   // ==========================================================
   // Bus power synchroniser
   logic pwr_meta_q;
   logic pwr_sync_q;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         pwr_meta_q <= 1'b0;
         pwr_sync_q <= 1'b0;
      end else begin
         pwr_meta_q <= BUS_PWR_I;
         pwr_sync_q <= pwr_meta_q;
      end
   end

   // ==========================================================
   // Communication state
   lcsm_state_t state_q;
   lcsm_state_t state_d;
   logic [31:0] idle_cnt_q;
   logic [31:0] idle_cnt_d;
   wire         activity = BREAK_SEEN_I | HEADER_SEEN_I;
   // A start without bus power is refused; the host should wait for ready.
   wire         start_ok = START_I & pwr_sync_q;
   wire         timed_out = (idle_cnt_q == CNT_LAST);

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start_ok && !STOP_I)
               state_d = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            if (STOP_I)
               state_d = ST_IDLE;
            else if (!activity && timed_out)
               state_d = ST_INACTIVE;
            else
               state_d = ST_ACTIVE;
         end
         ST_INACTIVE: begin
            if (STOP_I)
               state_d = ST_IDLE;
            else if (activity)
               state_d = ST_ACTIVE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // The counter only runs while active, so it saturates at the timeout point.
   always_comb begin
      if (state_q != ST_ACTIVE || activity)
         idle_cnt_d = '0;
      else if (timed_out)
         idle_cnt_d = idle_cnt_q;
      else
         idle_cnt_d = idle_cnt_q + 32'h0000_0001;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         state_q    <= ST_IDLE;
         idle_cnt_q <= '0;
      end else begin
         state_q    <= state_d;
         idle_cnt_q <= idle_cnt_d;
      end
   end

   // ==========================================================
   // Sleep flag
   logic sleep_q;

   // Wake wins over a request for sleep in the same cycle.
   always_ff @(posedge CLK_I) begin
      if (RST_I)
         sleep_q <= 1'b0;
      else if (WAKE_REQ_I || BREAK_SEEN_I)
         sleep_q <= 1'b0;
      else if (SLEEP_REQ_I)
         sleep_q <= 1'b1;
   end

   // ==========================================================
   // Last error capture
   lcsm_err_snap_t err_q;
   lcsm_err_snap_t err_d;
   wire            carries_vals = (ERR_I.code == ERR_READBACK) || (ERR_I.code == ERR_CHECKSUM);
   wire            carries_id   = (ERR_I.code != ERR_NONE) && (ERR_I.code != ERR_UNKN_ID);

   always_comb begin
      err_d.code     = ERR_I.code;
      err_d.received = carries_vals ? ERR_I.received : VAL_RESET;
      err_d.expected = carries_vals ? ERR_I.expected : VAL_RESET;
      if (!carries_id)
         err_d.id = ID_RESET;
      else if (ERR_I.id_valid)
         err_d.id = ERR_I.id;
      else
         err_d.id = ID_NONE;
   end

   always_ff @(posedge CLK_I) begin
      if (RST_I)
         err_q <= '{code: ERR_NONE, id: ID_RESET, received: VAL_RESET, expected: VAL_RESET};
      else if (ERR_I.strobe)
         err_q <= err_d;
   end

   // ==========================================================
   // Fault latch
   logic               fault_q;
   logic [FAULT_W-1:0] fault_code_q;

   // A new fault beats a clear in the same cycle; the first code is kept.
   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         fault_q      <= 1'b0;
         fault_code_q <= FAULT_NONE[FAULT_W-1:0];
      end else if (FAULT_I && !fault_q) begin
         fault_q      <= 1'b1;
         fault_code_q <= FAULT_CODE_I;
      end else if (FAULT_CLR_I && !FAULT_I) begin
         fault_q      <= 1'b0;
         fault_code_q <= FAULT_NONE[FAULT_W-1:0];
      end
   end

   // ==========================================================
   // Schedule index
   logic [SCHED_W-1:0] sched_q;

   // Index is only tracked as master; a slave-only host must ignore it.
   always_ff @(posedge CLK_I) begin
      if (RST_I)
         sched_q <= '0;
      else if (MASTER_I)
         sched_q <= SCHED_IDX_I;
   end

   // ==========================================================
   // Outputs
   wire [1:0] state_code = (state_q == ST_ACTIVE)   ? COMM_ACTIVE :
                           (state_q == ST_INACTIVE) ? COMM_INACTIVE : COMM_IDLE;

   assign COMM_STATE_O = state_code;
   assign COMM_EN_O    = (state_q != ST_IDLE);
   assign SLEEP_O      = sleep_q;
   assign XCVR_READY_O = pwr_sync_q;
   assign LAST_ERR_O   = err_q;
   assign FAULT_O      = fault_q;
   assign FAULT_CODE_O = fault_q ? fault_code_q : FAULT_NONE[FAULT_W-1:0];
   assign SCHED_IDX_O  = sched_q;

endmodule : lcsm_top

`default_nettype wire

// File: inc/lcsm_pkg.sv
// What this block does
// - Reset leaves state idle, no communication.
// - Start trigger moves idle to active when bus is powered.
// - Stop returns active or inactive to idle.
// - Headers seen keep the state active.
// - Four silent seconds make the state inactive.
// - Break or header returns inactive to active.
// - Inactive never puts the device asleep.
// - Sleep flag set by host, cleared on wake.
// - Received break also clears the sleep flag.
// - Ready flag follows bus power.
// - Hold coded result of last frame attempt.
// - Capture received and expected values on readback or checksum error.
// - Record frame identifier of last error other than unknown id.
// - Fault code reads zero without fault flag.
// - Faults latch independent of host requests.
// - Report running schedule index as master.
// - Error codes: none zero up to checksum six.
// - Error other than unknown id without identifier records identifier 64.
`default_nettype none

package lcsm_pkg;

   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned INACT_TIME_S    = 4;
   localparam longint unsigned INACT_CYCLES = longint'(INACT_TIME_S) * longint'(CLK_HZ);

   // ==========================================================
   // Encodings
   localparam logic [1:0] COMM_IDLE     = 2'h0;
   localparam logic [1:0] COMM_ACTIVE   = 2'h1;
   localparam logic [1:0] COMM_INACTIVE = 2'h2;

   localparam logic [2:0] ERR_NONE     = 3'h0;
   localparam logic [2:0] ERR_UNKN_ID  = 3'h1;
   localparam logic [2:0] ERR_FORM     = 3'h2;
   localparam logic [2:0] ERR_FRAMING  = 3'h3;
   localparam logic [2:0] ERR_READBACK = 3'h4;
   localparam logic [2:0] ERR_TIMEOUT  = 3'h5;
   localparam logic [2:0] ERR_CHECKSUM = 3'h6;

   localparam logic [6:0] ID_NONE  = 7'h40;
   localparam logic [6:0] ID_RESET = 7'h00;
   localparam logic [7:0] VAL_RESET = 8'h00;
   localparam logic [15:0] FAULT_NONE = 16'h0000;

   typedef enum {ST_IDLE, ST_ACTIVE, ST_INACTIVE} lcsm_state_t;

   // Error report from the frame engine, valid for one cycle on the strobe.
   typedef struct packed {
      logic       strobe;
      logic [2:0] code;
      logic       id_valid;
      logic [6:0] id;
      logic [7:0] received;
      logic [7:0] expected;
   } lcsm_err_t;

   // Captured error snapshot as seen by the host.
   typedef struct packed {
      logic [2:0] code;
      logic [6:0] id;
      logic [7:0] received;
      logic [7:0] expected;
   } lcsm_err_snap_t;

endpackage : lcsm_pkg

`default_nettype wire

// File: sim/lcsm_monitor.sv
`default_nettype none
module lcsm_monitor
   import lcsm_pkg::*;
#(parameter longint unsigned INACT_COUNT = 20, parameter int unsigned SCHED_W = 8, parameter int unsigned FAULT_W = 16)
(
   input wire logic CLK_I, RST_I, START_I, STOP_I, SLEEP_REQ_I, WAKE_REQ_I, MASTER_I, BREAK_SEEN_I,
   input wire logic HEADER_SEEN_I, FAULT_I, XCVR_READY_O, SLEEP_O, FAULT_O, COMM_EN_O,
   input wire logic [SCHED_W-1:0] SCHED_IDX_I, SCHED_IDX_O,
   input wire logic [FAULT_W-1:0] FAULT_CODE_I, FAULT_CODE_O,
   input wire lcsm_err_t ERR_I,
   input wire lcsm_err_snap_t LAST_ERR_O,
   input wire logic [1:0] COMM_STATE_O
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // Quiet cycles spent active; one beyond the timeout means it never fired.
   int quiet_q;
   wire act = BREAK_SEEN_I | HEADER_SEEN_I;
   always_ff @(posedge CLK_I) quiet_q <= (RST_I || COMM_STATE_O != COMM_ACTIVE || act) ? 0 : quiet_q + 1;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   chk_start_active: assert property (COMM_STATE_O == COMM_IDLE && START_I && XCVR_READY_O && !STOP_I
      |=> COMM_STATE_O == COMM_ACTIVE) else $error("Start did not activate.");
   chk_stop_idle: assert property (STOP_I |=> COMM_STATE_O == COMM_IDLE) else $error("Stop ignored.");
   chk_activity_wakes: assert property (COMM_STATE_O != COMM_IDLE && act && !STOP_I
      |=> COMM_STATE_O == COMM_ACTIVE) else $error("Activity did not hold active.");
   chk_quiet_bound: assert property (quiet_q <= INACT_COUNT) else $error("Timeout late.");
   chk_no_auto_sleep: assert property (!SLEEP_O && !SLEEP_REQ_I |=> !SLEEP_O) else $error("Unasked sleep.");
   chk_wake_clears: assert property (SLEEP_O && (WAKE_REQ_I || BREAK_SEEN_I) |=> !SLEEP_O)
      else $error("Wake ignored.");
   chk_fault_zero: assert property (!FAULT_O |-> FAULT_CODE_O == '0) else $error("Stray fault code.");
   chk_enable_follows: assert property (COMM_EN_O == (COMM_STATE_O != COMM_IDLE))
      else $error("Enable disagrees with state.");
   chk_fault_latch: assert property (FAULT_I && !FAULT_O |=> FAULT_O && FAULT_CODE_O == $past(FAULT_CODE_I))
      else $error("Fault not latched.");
   chk_err_code: assert property (ERR_I.strobe |=> LAST_ERR_O.code == $past(ERR_I.code))
      else $error("Error code lost.");
   chk_err_no_id: assert property (ERR_I.strobe && !ERR_I.id_valid && ERR_I.code > ERR_UNKN_ID
      |=> LAST_ERR_O.id == ID_NONE) else $error("Missing id marker.");
   chk_sched_track: assert property (MASTER_I |=> SCHED_IDX_O == $past(SCHED_IDX_I))
      else $error("Schedule index stale.");
   cover property (COMM_STATE_O == COMM_INACTIVE);
   cover property (SLEEP_O ##1 !SLEEP_O);
   cover property (FAULT_O);
endmodule : lcsm_monitor
bind lcsm_top lcsm_monitor #(.INACT_COUNT(INACT_COUNT), .SCHED_W(SCHED_W), .FAULT_W(FAULT_W)) i_lcsm_monitor (
   .CLK_I, .RST_I, .START_I, .STOP_I, .SLEEP_REQ_I, .WAKE_REQ_I, .MASTER_I, .BREAK_SEEN_I, .HEADER_SEEN_I,
   .FAULT_I, .XCVR_READY_O, .SLEEP_O, .FAULT_O, .COMM_EN_O, .SCHED_IDX_I, .SCHED_IDX_O, .FAULT_CODE_I, .FAULT_CODE_O,
   .ERR_I, .LAST_ERR_O, .COMM_STATE_O);
`default_nettype wire

// File: sim/lcsm_partner.sv
`default_nettype none
module lcsm_partner
   import lcsm_pkg::*;
(
   input  wire logic CLK_I,
   output logic      break_o,
   output logic      header_o,
   output lcsm_err_t err_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      break_o = 1'b0;
      header_o = 1'b0;
      err_o = '0;
   end
   // ==========
   // Error fields scramble after the strobe, so a stale capture cannot pass.
   task automatic send(input logic brk, input logic hdr, input lcsm_err_t e);
      @(posedge CLK_I);
      break_o <= brk;
      header_o <= hdr;
      err_o <= e;
      @(posedge CLK_I);
      break_o <= 1'b0;
      header_o <= 1'b0;
      err_o <= {1'b0, ~e[26:0]};
      #1;
   endtask : send
endmodule : lcsm_partner
`default_nettype wire

// File: sim/test_lcsm_top.sv
`default_nettype none
module test_lcsm_top
   import lcsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int INACT = 20;
   localparam logic [31:0] ZERO = 32'h0000_0000, ONE = 32'h0000_0001;
   logic clk_i = 1'b0, rst_i = 1'b1, master_i = 1'b0, bus_pwr_i = 1'b1, brk, hdr;
   logic [5:0] host = '0;
   logic [7:0] sched_idx_i = '0, sched_idx_o;
   logic [15:0] fault_code_i = '0, fault_code_o;
   logic [1:0] comm_state_o;
   logic comm_en_o, sleep_o, xcvr_ready_o, fault_o;
   lcsm_err_t err;
   lcsm_err_snap_t last_err_o;
   int err_count = 0, samples_checked = 0, cyc = 0;
   lcsm_partner i_lcsm_partner (.CLK_I(clk_i), .break_o(brk), .header_o(hdr), .err_o(err));
   // Host strobes are one vector: start, stop, sleep, wake, fault, fault clear.
   lcsm_top #(.INACT_COUNT(INACT)) i_lcsm_top (
      .CLK_I(clk_i), .RST_I(rst_i), .START_I(host[5]), .STOP_I(host[4]), .SLEEP_REQ_I(host[3]),
      .WAKE_REQ_I(host[2]), .MASTER_I(master_i), .SCHED_IDX_I(sched_idx_i), .BREAK_SEEN_I(brk),
      .HEADER_SEEN_I(hdr), .ERR_I(err), .FAULT_I(host[1]), .FAULT_CODE_I(fault_code_i), .FAULT_CLR_I(host[0]),
      .BUS_PWR_I(bus_pwr_i), .COMM_STATE_O(comm_state_o), .COMM_EN_O(comm_en_o), .SLEEP_O(sleep_o),
      .XCVR_READY_O(xcvr_ready_o), .LAST_ERR_O(last_err_o), .FAULT_O(fault_o), .FAULT_CODE_O(fault_code_o),
      .SCHED_IDX_O(sched_idx_o));
   initial forever #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         complete_run();
      end
   end
   // ==========
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic pulse(input logic [5:0] v);
      @(posedge clk_i);
      host <= v;
      @(posedge clk_i);
      host <= '0;
      #1;
   endtask : pulse
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_cyc
   task automatic complete_run();
      $display("Compares %0d, mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   // ==========
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_cyc(3);
      chk(32'(comm_state_o), 32'(COMM_IDLE));
      chk({30'h0, comm_en_o, sleep_o}, ZERO);
      @(posedge clk_i) bus_pwr_i <= 1'b0;
      wait_cyc(3);
      chk(32'(xcvr_ready_o), ZERO);
      pulse(6'h20);
      chk(32'(comm_state_o), 32'(COMM_IDLE));
      @(posedge clk_i) bus_pwr_i <= 1'b1;
      wait_cyc(3);
      chk(32'(xcvr_ready_o), ONE);
      pulse(6'h20);
      chk(32'(comm_state_o), 32'(COMM_ACTIVE));
      chk(32'(comm_en_o), ONE);
      for (int i = 0; i < 4; i++) begin
         i_lcsm_partner.send(1'b0, 1'b1, '0);
         wait_cyc(INACT - 5);
         chk(32'(comm_state_o), 32'(COMM_ACTIVE));
      end
      wait_cyc(10);
      chk(32'(comm_state_o), 32'(COMM_INACTIVE));
      chk(32'(sleep_o), ZERO);
      i_lcsm_partner.send(1'b1, 1'b0, '0);
      chk(32'(comm_state_o), 32'(COMM_ACTIVE));
      wait_cyc(INACT + 5);
      pulse(6'h10);
      chk(32'(comm_state_o), 32'(COMM_IDLE));
      pulse(6'h20);
      pulse(6'h10);
      chk(32'(comm_state_o), 32'(COMM_IDLE));
      $display("Test state done");
      pulse(6'h08);
      chk(32'(sleep_o), ONE);
      pulse(6'h04);
      chk(32'(sleep_o), ZERO);
      pulse(6'h08);
      i_lcsm_partner.send(1'b1, 1'b0, '0);
      chk(32'(sleep_o), ZERO);
      $display("Test sleep done");
      for (int c = 0; c < 7; c++) begin
         i_lcsm_partner.send(1'b0, 1'b0, {1'b1, 3'(c), c[0], 7'h21, 8'h5A, 8'hA5});
         chk(32'(last_err_o), {6'h0, 3'(c), c < 2 ? ID_RESET : c[0] ? 7'h21 : ID_NONE,
            (c == 4 || c == 6) ? 16'h5AA5 : 16'h0000});
      end
      $display("Test errors done");
      @(posedge clk_i) fault_code_i <= 16'h1234;
      pulse(6'h02);
      chk({fault_o, 15'h0000, fault_code_o}, 32'h8000_1234);
      pulse(6'h01);
      chk({fault_o, 15'h0000, fault_code_o}, ZERO);
      @(posedge clk_i) {master_i, sched_idx_i} <= {1'b1, 8'h05};
      wait_cyc(2);
      chk(32'(sched_idx_o), 32'h0000_0005);
      @(posedge clk_i) {master_i, sched_idx_i} <= {1'b0, 8'h09};
      wait_cyc(2);
      chk(32'(sched_idx_o), 32'h0000_0005);
      $display("Test fault and schedule done");
      complete_run();
   end
endmodule : test_lcsm_top
`default_nettype wire
